/* File: inc/alusf_pkg.sv */
// Package of constants and types for the ALU status flag block
package alusf_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] ALUSF_FLAGS_OFF = 5'h00;
  localparam logic [4:0] ALUSF_OPA_OFF = 5'h04;
  localparam logic [4:0] ALUSF_OPW_OFF = 5'h08;
  localparam logic [4:0] ALUSF_CMD_OFF = 5'h0c;
  localparam logic [4:0] ALUSF_RESULT_OFF = 5'h10;

  // ==========================================================
  // Flag bit positions
  localparam int ALUSF_C_POS = 0;
  localparam int ALUSF_DC_POS = 1;
  localparam int ALUSF_Z_POS = 2;
  localparam int ALUSF_OV_POS = 3;
  localparam int ALUSF_N_POS = 4;

  // ==========================================================
  // Command register fields
  localparam int ALUSF_CMD_OP_LSB = 0;
  localparam int ALUSF_CMD_BIT_LSB = 4;
  localparam int ALUSF_CMD_DEST_POS = 7;

  // ==========================================================
  // Reset values
  localparam logic [4:0] ALUSF_FLAGS_RST = 5'h00;
  localparam logic [7:0] ALUSF_BYTE_RST = 8'h00;

  // ==========================================================
  // Flag update masks
  localparam logic [4:0] ALUSF_MASK_ALL = 5'h1f;
  localparam logic [4:0] ALUSF_MASK_ROT = 5'h17;
  localparam logic [4:0] ALUSF_MASK_Z = 5'h04;
  localparam logic [4:0] ALUSF_MASK_NONE = 5'h00;

  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    ALUSF_ADD_W_FILE_OP = 4'h0,
    ALUSF_ADD_LITERAL_OP = 4'h1,
    ALUSF_LITERAL_MINUS_W_OP = 4'h2,
    ALUSF_FILE_MINUS_W_OP = 4'h3,
    ALUSF_ROTATE_RIGHT_OP = 4'h4,
    ALUSF_ROTATE_LEFT_OP = 4'h5,
    ALUSF_CLEAR_FILE_OP = 4'h6,
    ALUSF_BIT_CLEAR_OP = 4'h7,
    ALUSF_BIT_SET_OP = 4'h8,
    ALUSF_NIBBLE_SWAP_OP = 4'h9,
    ALUSF_FILE_TO_FILE_MOVE_OP = 4'ha,
    ALUSF_MOVE_W_TO_FILE_OP = 4'hb
  } alusf_op_type;

endpackage

/* File: rtl/alusf_status_flags.sv */
// ALU status flag register with Avalon-MM register access
//
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module alusf_status_flags (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [7:0] o_flags
);

  // ==========================================================
  // State
  logic ack_reg, ack_next;
  logic [4:0] flags_reg, flags_next;
  logic [7:0] opa_reg, opa_next;
  logic [7:0] opw_reg, opw_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] result_reg, result_next;
  logic [31:0] rdata_reg, rdata_next;

  logic req, accept, exec;
  alusf_pkg::alusf_op_type op;
  logic dest_flags;
  logic [2:0] bit_sel;
  logic [7:0] src_f, a_in, b_in, r;
  logic sub;
  logic [4:0] lo5;
  logic [8:0] sum9;
  logic [4:0] calc, mask;

  // ==========================================================
  // Bus handshake: one wait cycle per request
  assign req = i_avs_read | i_avs_write;
  assign accept = req & ack_reg;
  assign o_avs_waitrequest = req & ~ack_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_flags = {3'h0, flags_reg};
  assign exec = accept & i_avs_write & i_avs_byteenable[0] & (i_avs_address == alusf_pkg::ALUSF_CMD_OFF);

  assign op = alusf_pkg::alusf_op_type'(i_avs_writedata[alusf_pkg::ALUSF_CMD_OP_LSB +: 4]);
  assign bit_sel = i_avs_writedata[alusf_pkg::ALUSF_CMD_BIT_LSB +: 3];
  assign dest_flags = i_avs_writedata[alusf_pkg::ALUSF_CMD_DEST_POS];

  // ==========================================================
  // Operation datapath
  always_comb begin
    src_f = dest_flags ? {3'h0, flags_reg} : opa_reg;
    a_in = src_f;
    b_in = opw_reg;
    sub = 1'b0;
    r = src_f;
    mask = alusf_pkg::ALUSF_MASK_NONE;
    calc = flags_reg;
    lo5 = 5'h00;
    sum9 = 9'h000;
    case (op)
      alusf_pkg::ALUSF_ADD_W_FILE_OP,
      alusf_pkg::ALUSF_ADD_LITERAL_OP,
      alusf_pkg::ALUSF_LITERAL_MINUS_W_OP,
      alusf_pkg::ALUSF_FILE_MINUS_W_OP: begin
        if (op == alusf_pkg::ALUSF_ADD_LITERAL_OP || op == alusf_pkg::ALUSF_LITERAL_MINUS_W_OP) begin
          a_in = opa_reg;
        end
        sub = (op == alusf_pkg::ALUSF_LITERAL_MINUS_W_OP) || (op == alusf_pkg::ALUSF_FILE_MINUS_W_OP);
        if (sub) begin
          b_in = ~opw_reg;
        end
        lo5 = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, sub};
        sum9 = {1'b0, a_in} + {1'b0, b_in} + {8'h00, sub};
        r = sum9[7:0];
        mask = alusf_pkg::ALUSF_MASK_ALL;
        calc[alusf_pkg::ALUSF_DC_POS] = lo5[4];
        calc[alusf_pkg::ALUSF_C_POS] = sum9[8];
        calc[alusf_pkg::ALUSF_OV_POS] = (a_in[7] == b_in[7]) && (sum9[7] != a_in[7]);
      end
      alusf_pkg::ALUSF_ROTATE_RIGHT_OP: begin
        r = {flags_reg[alusf_pkg::ALUSF_C_POS], src_f[7:1]};
        mask = alusf_pkg::ALUSF_MASK_ROT;
        calc[alusf_pkg::ALUSF_DC_POS] = src_f[4];
        calc[alusf_pkg::ALUSF_C_POS] = src_f[0];
      end
      alusf_pkg::ALUSF_ROTATE_LEFT_OP: begin
        r = {src_f[6:0], flags_reg[alusf_pkg::ALUSF_C_POS]};
        mask = alusf_pkg::ALUSF_MASK_ROT;
        calc[alusf_pkg::ALUSF_DC_POS] = src_f[3];
        calc[alusf_pkg::ALUSF_C_POS] = src_f[7];
      end
      alusf_pkg::ALUSF_CLEAR_FILE_OP: begin
        r = 8'h00;
        mask = alusf_pkg::ALUSF_MASK_Z;
      end
      alusf_pkg::ALUSF_BIT_CLEAR_OP: r = src_f & ~(8'h01 << bit_sel);
      alusf_pkg::ALUSF_BIT_SET_OP: r = src_f | (8'h01 << bit_sel);
      alusf_pkg::ALUSF_NIBBLE_SWAP_OP: r = {src_f[3:0], src_f[7:4]};
      alusf_pkg::ALUSF_FILE_TO_FILE_MOVE_OP: r = opa_reg;
      alusf_pkg::ALUSF_MOVE_W_TO_FILE_OP: r = opw_reg;
      default: r = src_f;
    endcase
    calc[alusf_pkg::ALUSF_N_POS] = r[7];
    calc[alusf_pkg::ALUSF_Z_POS] = (r == 8'h00);
  end

  // ==========================================================
  // Register next values
  always_comb begin
    ack_next = o_avs_waitrequest;
    flags_next = flags_reg;
    opa_next = opa_reg;
    opw_next = opw_reg;
    cmd_next = cmd_reg;
    result_next = result_reg;
    rdata_next = rdata_reg;
    if (accept && i_avs_write && i_avs_byteenable[0]) begin
      case (i_avs_address)
        alusf_pkg::ALUSF_FLAGS_OFF: flags_next = i_avs_writedata[4:0];
        alusf_pkg::ALUSF_OPA_OFF: opa_next = i_avs_writedata[7:0];
        alusf_pkg::ALUSF_OPW_OFF: opw_next = i_avs_writedata[7:0];
        alusf_pkg::ALUSF_CMD_OFF: begin
          cmd_next = i_avs_writedata[7:0];
          // Flag-updating ops block the destination write to all five flags
          if (dest_flags && mask == alusf_pkg::ALUSF_MASK_NONE) begin
            flags_next = r[4:0];
          end else begin
            flags_next = (flags_reg & ~mask) | (calc & mask);
          end
          result_next = dest_flags ? {3'h0, flags_next} : r;
        end
        default: flags_next = flags_reg;
      endcase
    end
    if (o_avs_waitrequest && i_avs_read) begin
      case (i_avs_address)
        alusf_pkg::ALUSF_FLAGS_OFF: rdata_next = {27'h0000000, flags_reg};
        alusf_pkg::ALUSF_OPA_OFF: rdata_next = {24'h000000, opa_reg};
        alusf_pkg::ALUSF_OPW_OFF: rdata_next = {24'h000000, opw_reg};
        alusf_pkg::ALUSF_CMD_OFF: rdata_next = {24'h000000, cmd_reg};
        alusf_pkg::ALUSF_RESULT_OFF: rdata_next = {24'h000000, result_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
      flags_reg <= alusf_pkg::ALUSF_FLAGS_RST;
      opa_reg <= alusf_pkg::ALUSF_BYTE_RST;
      opw_reg <= alusf_pkg::ALUSF_BYTE_RST;
      cmd_reg <= alusf_pkg::ALUSF_BYTE_RST;
      result_reg <= alusf_pkg::ALUSF_BYTE_RST;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= ack_next;
      flags_reg <= flags_next;
      opa_reg <= opa_next;
      opw_reg <= opw_next;
      cmd_reg <= cmd_next;
      result_reg <= result_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Checks
  logic exec_q, dest_q;
  logic [3:0] op_q;
  logic [7:0] src_q, w_q, lit_q;
  logic [4:0] fl_q;
  always_ff @(posedge i_clk) begin
    exec_q <= exec & ~i_sys_rst;
    dest_q <= dest_flags;
    op_q <= op;
    src_q <= src_f;
    w_q <= opw_reg;
    lit_q <= opa_reg;
    fl_q <= flags_reg;
  end

  add_carry_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h0 |-> flags_reg[0] == ((9'(src_q) + 9'(w_q)) > 9'h0ff))
    else $error("add carry wrong");
  sub_borrow_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h3 |-> flags_reg[0] == (src_q >= w_q))
    else $error("subtract carry wrong");
  add_nibble_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h1 |-> flags_reg[1] == ((5'(lit_q[3:0]) + 5'(w_q[3:0])) > 5'h0f))
    else $error("nibble carry wrong");
  rot_right_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h4 && !dest_q |-> flags_reg[0] == src_q[0] && flags_reg[1] == src_q[4])
    else $error("rotate right flags wrong");
  rot_left_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h5 && !dest_q |-> flags_reg[0] == src_q[7] && flags_reg[1] == src_q[3])
    else $error("rotate left flags wrong");
  clear_flags_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h6 && dest_q |-> flags_reg == (fl_q | 5'h04))
    else $error("clear on flags wrong");
  keep_flags_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q >= 4'h7 && !dest_q |-> flags_reg == fl_q)
    else $error("flags disturbed");
  zero_neg_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q <= 4'h3 && !dest_q |-> flags_reg[2] == (result_reg == 8'h00) && flags_reg[4] == result_reg[7])
    else $error("zero or negative wrong");
  upper_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && dest_q |-> result_reg[7:5] == 3'h0 ##1 o_flags[7:5] == 3'h0)
    else $error("upper flag bits set");
  wait_once_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("wait longer than one cycle");
  dest_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && dest_q && (op_q == 4'h4 || op_q == 4'h5) |-> flags_reg[3] == fl_q[3])
    else $error("flag write not suppressed");
  clear_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    exec_q && op_q == 4'h6 && !dest_q |-> flags_reg == (fl_q | 5'h04) && result_reg == 8'h00)
    else $error("clear file flags wrong");

endmodule // alusf_status_flags

/* File: tb/tb_alusf_status_flags.sv */
// Self-checking testbench for the ALU status flag block
`timescale 1ns/10ps
module tb_alusf_status_flags;
  logic i_clk;
  logic i_sys_rst;
  logic [4:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [7:0] o_flags;
  int err_count = 0;
  int check_count = 0;

  alusf_status_flags alusf_status_flags_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_flags(o_flags)
  );

  // ==========================================================
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ==========================================================
  // Report and bus tasks
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_of_test();
    end
    rd = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hf, x);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, 4'hf, x);
    chk(x, {24'h0, exp});
  endtask

  task automatic ld(input logic [7:0] a, input logic [7:0] w);
    wr(alusf_pkg::ALUSF_OPA_OFF, a);
    wr(alusf_pkg::ALUSF_OPW_OFF, w);
  endtask

  task automatic op(input alusf_pkg::alusf_op_type c, input logic [2:0] b, input logic dest,
                    input logic [7:0] exp);
    wr(alusf_pkg::ALUSF_CMD_OFF, {dest, b, c});
    @(posedge i_clk);
    chk({24'h0, o_flags}, {24'h0, exp});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({24'h0, o_flags}, 32'h0);
    rd(alusf_pkg::ALUSF_FLAGS_OFF, 8'h00);
    rd(5'h14, 8'h00);
  endtask

  task automatic t_add();
    ld(8'h0f, 8'h01);
    op(alusf_pkg::ALUSF_ADD_W_FILE_OP, 3'h0, 1'b0, 8'h02);
    rd(alusf_pkg::ALUSF_RESULT_OFF, 8'h10);
    ld(8'h80, 8'h80);
    op(alusf_pkg::ALUSF_ADD_W_FILE_OP, 3'h0, 1'b0, 8'h0d);
    ld(8'h7f, 8'h01);
    op(alusf_pkg::ALUSF_ADD_LITERAL_OP, 3'h0, 1'b0, 8'h1a);
  endtask

  task automatic t_sub();
    ld(8'h05, 8'h06);
    op(alusf_pkg::ALUSF_LITERAL_MINUS_W_OP, 3'h0, 1'b0, 8'h10);
    ld(8'h06, 8'h06);
    op(alusf_pkg::ALUSF_FILE_MINUS_W_OP, 3'h0, 1'b0, 8'h07);
    ld(8'h80, 8'h01);
    op(alusf_pkg::ALUSF_FILE_MINUS_W_OP, 3'h0, 1'b0, 8'h09);
  endtask

  task automatic t_rot();
    wr(alusf_pkg::ALUSF_FLAGS_OFF, 8'h08);
    ld(8'h19, 8'h00);
    op(alusf_pkg::ALUSF_ROTATE_RIGHT_OP, 3'h0, 1'b0, 8'h0b);
    rd(alusf_pkg::ALUSF_RESULT_OFF, 8'h0c);
    wr(alusf_pkg::ALUSF_FLAGS_OFF, 8'h00);
    ld(8'h80, 8'h00);
    op(alusf_pkg::ALUSF_ROTATE_LEFT_OP, 3'h0, 1'b0, 8'h05);
    wr(alusf_pkg::ALUSF_RESULT_OFF, 8'h55);
    rd(alusf_pkg::ALUSF_RESULT_OFF, 8'h00);
    wr(alusf_pkg::ALUSF_FLAGS_OFF, 8'h0a);
    op(alusf_pkg::ALUSF_ROTATE_RIGHT_OP, 3'h0, 1'b1, 8'h08);
    rd(alusf_pkg::ALUSF_RESULT_OFF, 8'h08);
    op(alusf_pkg::ALUSF_CLEAR_FILE_OP, 3'h0, 1'b0, 8'h0c);
    rd(alusf_pkg::ALUSF_RESULT_OFF, 8'h00);
  endtask

  task automatic t_dest();
    wr(alusf_pkg::ALUSF_FLAGS_OFF, 8'h1b);
    ld(8'h0a, 8'h15);
    op(alusf_pkg::ALUSF_CLEAR_FILE_OP, 3'h0, 1'b1, 8'h1f);
    op(alusf_pkg::ALUSF_BIT_CLEAR_OP, 3'h0, 1'b1, 8'h1e);
    op(alusf_pkg::ALUSF_BIT_SET_OP, 3'h0, 1'b1, 8'h1f);
    op(alusf_pkg::ALUSF_BIT_SET_OP, 3'h3, 1'b0, 8'h1f);
    op(alusf_pkg::ALUSF_NIBBLE_SWAP_OP, 3'h0, 1'b1, 8'h11);
    op(alusf_pkg::ALUSF_MOVE_W_TO_FILE_OP, 3'h0, 1'b1, 8'h15);
    op(alusf_pkg::ALUSF_FILE_TO_FILE_MOVE_OP, 3'h0, 1'b1, 8'h0a);
    wr(alusf_pkg::ALUSF_OPW_OFF, 8'h01);
    op(alusf_pkg::ALUSF_ADD_W_FILE_OP, 3'h0, 1'b1, 8'h00);
  endtask

  task automatic t_bus();
    logic [31:0] x;
    wr(alusf_pkg::ALUSF_FLAGS_OFF, 8'hff);
    rd(alusf_pkg::ALUSF_FLAGS_OFF, 8'h1f);
    bus(1'b1, alusf_pkg::ALUSF_FLAGS_OFF, 8'h00, 4'he, x);
    rd(alusf_pkg::ALUSF_FLAGS_OFF, 8'h1f);
    wr(5'h14, 8'h33);
    rd(5'h14, 8'h00);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    i_sys_rst = 1'b1;
    i_avs_address = 5'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_add();
    t_sub();
    t_rot();
    t_dest();
    t_bus();
    end_of_test();
  end

  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
endmodule // tb_alusf_status_flags
